// ===== scm_dev_model.sv
// behavioural model of the device end of the serial programming port
module scm_dev_model #(
  parameter int WBUF = 8, // write buffer bytes
  parameter int HOLD_NS = 400, // least program_hold_time that programs
  parameter logic [21:0] CODE_END = 22'h00ffff // last code address
) (
  input wire logic sclk,
  input wire logic sio,
  output logic dev_o,
  output logic dev_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [int]; // programmed cells, absent ones read erased
  logic [7:0] wbuf [64]; // write buffer
  logic [21:0] ptr; // table_pointer
  logic [7:0] w_reg, ctl, rd_b; // working reg, memory_control_reg, read byte
  logic [19:0] sh; // frame shift register, lsb first
  logic [3:0] cmd;
  int n, pend; // bit count; 1 program or 2 erase pending
  time t_hi;
  bit armed; // a real high was seen, so the fall out of x at reset is no clock
  initial begin
    ptr = 22'h0;
    ctl = 8'h0;
    n = 0;
    pend = 0;
    dev_oe = 1'b0;
    dev_o = 1'b0;
    foreach (wbuf[i]) wbuf[i] = 8'hff;
  end
  function automatic logic [7:0] rd(input logic [21:0] a);
    return mem.exists(a) ? mem[a] : 8'hff;
  endfunction : rd
  // commit the aligned region that holds the pointer
  task automatic commit();
    logic [21:0] b;
    int sz;
    sz = (pend == 2) ? 64 : WBUF;
    b = ptr & ~22'(sz - 1);
    for (int i = 0; i < sz; i++) begin
      if (pend == 2) mem[b + i] = 8'hff;
      else mem[b + i] = rd(22'(b + i)) & wbuf[i];
    end
    foreach (wbuf[i]) wbuf[i] = 8'hff;
  endtask : commit
  // run a complete frame
  task automatic exec();
    logic [15:0] p;
    p = sh[19:4];
    case (cmd)
      4'h0: begin // core instruction
        if (p[15:8] == 8'h0e) w_reg = p[7:0];
        if (p == 16'h6ef8) ptr[21:16] = w_reg[5:0];
        if (p == 16'h6ef7) ptr[15:8] = w_reg;
        if (p == 16'h6ef6) ptr[7:0] = w_reg;
        if (p[15:12] == 4'h8 && p[7:0] == 8'ha6) ctl[p[11:9]] = 1'b1;
        if (p[15:12] == 4'h9 && p[7:0] == 8'ha6) ctl[p[11:9]] = 1'b0;
        if (ctl[1]) pend = ctl[2] ? (ctl[4] ? 2 : 1) : 0;
        ctl[1] = 1'b0;
      end
      4'hd, 4'hf: begin // two bytes into the buffer
        wbuf[ptr[5:0] & 6'(WBUF - 1)] = p[7:0];
        wbuf[(ptr[5:0] + 6'h1) & 6'(WBUF - 1)] = p[15:8];
        if (cmd == 4'hd) ptr = ptr + 22'h2;
        else if (ctl[6]) mem[ptr] = ptr[0] ? p[15:8] : p[7:0];
        else pend = 1;
      end
      default: ;
    endcase
  endtask : exec
  // rising clock: start of hold, read bits out lsb first
  always @(posedge sclk) begin
    armed = 1'b1;
    if (n == 3) t_hi = $time;
    if (cmd == 4'h9 && n >= 12) begin
      dev_oe = 1'b1;
      dev_o = rd_b[n-12];
    end
  end
  // falling clock: end programming, capture bit
  always @(negedge sclk) if (armed) begin
    if (n == 3 && pend != 0 && $time - t_hi >= HOLD_NS) commit();
    if (n == 3) pend = 0;
    sh = {sio, sh[19:1]};
    n = n + 1;
    if (n == 4) cmd = sh[19:16];
    if (n == 12 && cmd == 4'h9) begin
      rd_b = rd(ptr);
      ptr = (ptr == CODE_END) ? 22'h0 : ptr + 22'h1;
    end
    if (n == 20) begin
      n = 0;
      dev_oe <= #60 1'b0;
      exec();
    end
  end
endmodule : scm_dev_model

// ===== scm_pkg.sv
// constants, codes and state type of the serial code memory programmer
package scm_pkg;
  // clock and link timing, figures in ns
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned SCLK_HALF_NS = 100; // least half period of the serial clock
  localparam int unsigned PROG_HOLD_NS = 1000000; // program_hold_time, plain default
  localparam int unsigned DISCHARGE_NS = 100000; // discharge_time, plain default
  localparam int unsigned TURN_NS = 100; // read_turnaround_delay, plain default
  // least times rounded up to whole cycles
  localparam int unsigned SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PROG_HOLD_CYC = (PROG_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DISCHARGE_CYC = (DISCHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TURN_CYC = (TURN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W = 24;
  // serial frame: 4 command bits then 16 payload bits, lsb first
  localparam int FRAME_BITS = 20;
  localparam logic [4:0] HOLD_BIT = 5'h03; // 4th clock of the frame
  localparam logic [4:0] TURN_BIT = 5'h0b; // 8th clock of the operand
  localparam logic [4:0] RX_FIRST = 5'h0c; // first clock of the read byte
  localparam logic [4:0] LAST_BIT = 5'h13;
  // 4-bit command codes
  localparam logic [3:0] CMD_CORE = 4'h0;
  localparam logic [3:0] CMD_RD_INC = 4'h9;
  localparam logic [3:0] CMD_WR_INC2 = 4'hd;
  localparam logic [3:0] CMD_WR_START = 4'hf;
  // core instruction fields recognised for the shadow state
  localparam logic [7:0] OP_MOVLW = 8'h0e;
  localparam logic [7:0] OP_MOVWF = 8'h6e;
  localparam logic [7:0] PTR_UPPER_ADDR = 8'hf8;
  localparam logic [7:0] PTR_HIGH_ADDR = 8'hf7;
  localparam logic [7:0] PTR_LOW_ADDR = 8'hf6;
  localparam logic [7:0] CTL_REG_ADDR = 8'ha6;
  localparam logic [3:0] OP_BSF = 4'h8;
  localparam logic [3:0] OP_BCF = 4'h9;
  // memory_control_reg bit positions
  localparam logic [2:0] PROG_SEL_POS = 3'h7;
  localparam logic [2:0] CFG_SEL_POS = 3'h6;
  localparam logic [2:0] ERASE_SEL_POS = 3'h4;
  localparam logic [2:0] WRITE_ENABLE_BIT_POS = 3'h2;
  localparam logic [2:0] WR_POS = 3'h1;
  // table pointer and buffer region
  localparam int PTR_W = 22;
  localparam int WBUF_LOG2 = 6; // largest write buffer, 64 bytes
  localparam logic [PTR_W-1:0] PTR_STEP_WR = 22'h000002;
  localparam logic [PTR_W-1:0] PTR_STEP_RD = 22'h000001;
  // register map of the controller
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_PAYLOAD = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_RDATA = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_PTR = 8'h10;
  localparam int CTRL_HOLD_POS = 4;
  localparam int STAT_REGION_POS = 1;
  localparam int STAT_NOEN_POS = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // serial engine states
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_HIGH = 3'h1,
    ST_LOW = 3'h2,
    ST_HOLD_HI = 3'h3,
    ST_HOLD_LO = 3'h4,
    ST_TURN = 3'h5
  } scm_state_e;
endpackage : scm_pkg

// ===== scm_prog_host.sv
// programmer that drives the serial code memory port, ordered over axi4-lite
// Operation
// RULE1 - device programs buffer region holding pointer
// RULE2 - after 1111, nop with 4th clock held high
// RULE3 - clock low ends programming, hold low discharge
// RULE4 - keep pointer in one region until programming
// RULE5 - write buffer 8 to 64, erase 64 bytes
// RULE6 - modify: read block, erase, rewrite whole block
// RULE7 - set write-enable before write-start, clear after
// RULE8 - block erase sequence ends with timed nop
// RULE9 - 1101 writes two bytes, pointer plus two
// RULE10 - 1111 writes two bytes, starts programming
// RULE11 - repeat load and program across erased block
// RULE12 - id bytes program like code, always readable
// RULE13 - id write loads first 8 bytes, erase first
// RULE14 - boot region uses normal code sequence
// RULE15 - config bytes: one byte per 1111
// RULE16 - load pointer explicitly for each config byte
// RULE17 - 1001 reads one byte, pointer plus one
// RULE18 - command lsb first, byte out lsb first
// RULE19 - clock low for turnaround after 8th operand clock
// RULE20 - table reads cover the whole address space
// RULE21 - pointer wraps at code end, reload id base; the shadow table_pointer steps on past code end and wraps only at 22 bits
// RULE22 - verify two bytes per program word
// RULE23 - 0000 executes payload as core instruction
// RULE24 - control bit positions for code memory access
// RULE25 - device ignores write-start without write-enable
// RULE26 - data taken on falling clock edge
module scm_prog_host
  import scm_pkg::*;
#(
  parameter int unsigned PROG_HOLD_CYCLES = PROG_HOLD_CYC // shorten in simulation
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic prog_serial_clock,
  input wire logic prog_serial_io_i,
  output logic prog_serial_io_o,
  output logic prog_serial_io_oe
);

  // matches a bit set or clear on memory_control_reg
  function automatic logic ctl_bit_op(input logic [15:0] pl, input logic [3:0] opc,
                                      input logic [2:0] pos);
    ctl_bit_op = (pl[15:12] == opc) && (pl[11:9] == pos) && (pl[8] == 1'b0)
                 && (pl[7:0] == CTL_REG_ADDR);
  endfunction : ctl_bit_op

  // timer reloads, narrowed to the timer width
  localparam logic [TMR_W-1:0] HALF_LD = TMR_W'(SCLK_HALF_CYC - 1);
  localparam logic [TMR_W-1:0] HOLD_LD = TMR_W'(PROG_HOLD_CYCLES - 1);
  localparam logic [TMR_W-1:0] DIS_LD = TMR_W'(DISCHARGE_CYC - 1);
  localparam logic [TMR_W-1:0] TURN_LD = TMR_W'(TURN_CYC - 1);

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // bus side storage
  logic [ADDR_W-1:0] aw_addr; // held write address
  logic aw_held; // write address taken
  logic [31:0] w_data; // held write data
  logic [3:0] w_strb; // held byte enables
  logic w_held; // write data taken
  logic [3:0] ctrl_cmd; // command code of the frame last started
  logic ctrl_hold; // hold the 4th clock for programming
  logic [15:0] payload; // payload of the next frame
  // serial engine
  scm_state_e state; // engine state
  scm_state_e next_state;
  logic [TMR_W-1:0] timer; // cycles left in the phase
  logic [4:0] bit_idx; // clock number within the frame
  logic [FRAME_BITS-1:0] tx; // outgoing frame, command then payload
  logic is_read; // frame is a table read
  logic hold_mode; // frame carries the programming hold
  logic [7:0] rx; // incoming read byte
  logic io_meta; // first synchroniser stage
  logic io_sync; // synchronised data line
  // shadow of device state
  logic [7:0] w_shadow; // last literal loaded
  logic [PTR_W-1:0] table_pointer; // shadow table pointer
  logic write_enable_bit; // shadow write enable
  logic [PTR_W-1-WBUF_LOG2:0] region; // region of the loaded buffer
  logic region_valid; // buffer holds data
  logic region_err; // sticky: pointer left the region
  logic wr_no_en; // sticky: write-start without enable

  // write channel decode
  wire wr_fire = aw_held && w_held && !s_axi_bvalid;
  wire busy = (state != ST_IDLE);
  wire wr_ctrl = wr_fire && (aw_addr == ADDR_CTRL);
  wire wr_payload = wr_fire && (aw_addr == ADDR_PAYLOAD);
  wire wr_status = wr_fire && (aw_addr == ADDR_STATUS);
  wire wr_mapped = wr_ctrl || wr_payload || wr_status;
  wire start = wr_ctrl && !busy && w_strb[0];
  wire [31:0] wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  wire [31:0] pay_merge = ({16'h0000, payload} & ~wmask) | (w_data & wmask);
  wire [1:0] wr_resp = (wr_mapped && !(wr_ctrl && busy)) ? RESP_OKAY : RESP_SLVERR;

  // write address and data channels, taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      s_axi_awready <= 1'b1;
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      s_axi_awready <= 1'b0;
      aw_addr <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      aw_held <= 1'b0;
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      s_axi_wready <= 1'b1;
      w_data <= '0;
      w_strb <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      s_axi_wready <= 1'b0;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      w_held <= 1'b0;
      s_axi_wready <= 1'b1;
    end
  end

  // write response once both halves are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_resp;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // command and payload registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      payload <= '0;
      ctrl_cmd <= CMD_CORE;
      ctrl_hold <= 1'b0;
    end else begin
      if (wr_payload) begin
        payload <= pay_merge[15:0];
      end
      if (start) begin
        ctrl_cmd <= w_data[3:0];
        ctrl_hold <= w_data[CTRL_HOLD_POS];
      end
    end
  end

  // read channel: mux of control, payload, status, read byte and shadow pointer
  wire rd_ok = (s_axi_araddr == ADDR_CTRL) || (s_axi_araddr == ADDR_PAYLOAD)
               || (s_axi_araddr == ADDR_STATUS) || (s_axi_araddr == ADDR_RDATA)
               || (s_axi_araddr == ADDR_PTR);
  wire [31:0] status_word = {28'h0000000, write_enable_bit, wr_no_en, region_err, busy};
  wire [31:0] rd_mux =
    (s_axi_araddr == ADDR_CTRL) ? {27'h0000000, ctrl_hold, ctrl_cmd} :
    (s_axi_araddr == ADDR_PAYLOAD) ? {16'h0000, payload} :
    (s_axi_araddr == ADDR_STATUS) ? status_word :
    (s_axi_araddr == ADDR_RDATA) ? {24'h000000, rx} :
    (s_axi_araddr == ADDR_PTR) ? {10'h000, table_pointer} : 32'h00000000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
    end
  end

  // engine decode
  wire tmr_done = (timer == '0);
  wire hold_here = hold_mode && (bit_idx == HOLD_BIT); // RULE2
  wire turn_here = is_read && (bit_idx == TURN_BIT); // RULE19
  wire last_bit = (bit_idx == LAST_BIT);
  wire falling = (state == ST_HIGH) && tmr_done && !hold_here;
  wire adv = ((state == ST_LOW) || (state == ST_HOLD_LO)) && tmr_done && !last_bit;
  wire [4:0] next_idx = start ? 5'h00 : (adv ? bit_idx + 5'h01 : bit_idx);
  wire next_clk_high = (next_state == ST_HIGH) || (next_state == ST_HOLD_HI);
  wire next_rx = is_read && (next_state != ST_IDLE)
                 && ((next_state == ST_TURN) || (next_idx >= RX_FIRST)); // RULE19
  wire next_io = start ? w_data[0] : ((next_idx <= LAST_BIT) ? tx[next_idx] : 1'b0); // RULE18
  wire [TMR_W-1:0] tmr_load =
    (next_state == ST_HOLD_HI) ? HOLD_LD :
    (next_state == ST_HOLD_LO) ? DIS_LD :
    (next_state == ST_TURN) ? TURN_LD : HALF_LD;

  // next engine state
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (start) next_state = ST_HIGH;
      end
      ST_HIGH: begin
        if (tmr_done) next_state = hold_here ? ST_HOLD_HI : ST_LOW; // RULE2
      end
      ST_HOLD_HI: begin
        if (tmr_done) next_state = ST_HOLD_LO; // RULE3
      end
      ST_HOLD_LO: begin
        if (tmr_done) next_state = ST_HIGH;
      end
      ST_LOW: begin
        if (tmr_done) begin
          if (last_bit) next_state = ST_IDLE;
          else if (turn_here) next_state = ST_TURN; // RULE19
          else next_state = ST_HIGH;
        end
      end
      ST_TURN: begin
        if (tmr_done) next_state = ST_HIGH;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // state, phase timer and clock counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
      timer <= '0;
      bit_idx <= '0;
    end else begin
      state <= next_state;
      timer <= (next_state != state) ? tmr_load : (tmr_done ? timer : timer - 1'b1);
      bit_idx <= next_idx;
    end
  end

  // frame latched at start
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx <= '0;
      is_read <= 1'b0;
      hold_mode <= 1'b0;
    end else if (start) begin
      tx <= {payload, w_data[3:0]}; // RULE18
      is_read <= (w_data[3:0] == CMD_RD_INC);
      hold_mode <= w_data[CTRL_HOLD_POS]; // RULE2 RULE8
    end
  end

  // pin drive: data changes with the rising clock, released while reading
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prog_serial_clock <= 1'b0;
      prog_serial_io_o <= 1'b0;
      prog_serial_io_oe <= 1'b1;
    end else begin
      prog_serial_clock <= next_clk_high; // RULE3
      prog_serial_io_o <= next_rx ? 1'b0 : next_io;
      prog_serial_io_oe <= !next_rx; // RULE19
    end
  end

  // data line synchroniser and read shift, lsb first at the falling edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      io_meta <= 1'b0;
      io_sync <= 1'b0;
      rx <= '0;
    end else begin
      io_meta <= prog_serial_io_i;
      io_sync <= io_meta;
      if (falling && is_read && (bit_idx >= RX_FIRST)) rx <= {io_sync, rx[7:1]}; // RULE26
    end
  end

  // shadow decode of the frame being started
  wire core_op = start && (w_data[3:0] == CMD_CORE); // RULE23
  wire movwf_op = core_op && (payload[15:8] == OP_MOVWF);
  wire set_write_enable_bit = core_op && ctl_bit_op(payload, OP_BSF, WRITE_ENABLE_BIT_POS);
  wire clr_write_enable_bit = core_op && ctl_bit_op(payload, OP_BCF, WRITE_ENABLE_BIT_POS);
  wire set_wr = core_op && ctl_bit_op(payload, OP_BSF, WR_POS);
  wire ld_buf = start && (w_data[3:0] == CMD_WR_INC2);
  wire go_prog = start && (w_data[3:0] == CMD_WR_START);
  wire rd_op = start && (w_data[3:0] == CMD_RD_INC);
  wire [PTR_W-1-WBUF_LOG2:0] cur_region = table_pointer[PTR_W-1:WBUF_LOG2];
  wire region_miss = (ld_buf || go_prog) && region_valid && (cur_region != region); // RULE4
  wire clr_region = wr_status && w_strb[0] && w_data[STAT_REGION_POS];
  wire clr_noen = wr_status && w_strb[0] && w_data[STAT_NOEN_POS];

  // shadow table pointer, loaded by core instructions and stepped by table ops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_shadow <= '0;
      table_pointer <= '0;
    end else begin
      if (core_op && (payload[15:8] == OP_MOVLW)) w_shadow <= payload[7:0];
      if (movwf_op && (payload[7:0] == PTR_UPPER_ADDR)) table_pointer[21:16] <= w_shadow[5:0];
      if (movwf_op && (payload[7:0] == PTR_HIGH_ADDR)) table_pointer[15:8] <= w_shadow; // RULE21
      if (movwf_op && (payload[7:0] == PTR_LOW_ADDR)) table_pointer[7:0] <= w_shadow; // RULE16
      if (ld_buf) table_pointer <= table_pointer + PTR_STEP_WR; // RULE11
      if (rd_op) table_pointer <= table_pointer + PTR_STEP_RD; // RULE22
    end
  end

  // write-enable shadow, buffer region tracking and sticky flags, set wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      write_enable_bit <= 1'b0;
      region <= '0;
      region_valid <= 1'b0;
      region_err <= 1'b0;
      wr_no_en <= 1'b0;
    end else begin
      if (set_write_enable_bit) write_enable_bit <= 1'b1; // RULE7
      else if (clr_write_enable_bit) write_enable_bit <= 1'b0;
      if (ld_buf) region <= cur_region; // RULE6 RULE13 RULE14
      if (ld_buf) region_valid <= 1'b1;
      else if (go_prog) region_valid <= 1'b0;
      if (region_miss) region_err <= 1'b1; // RULE4
      else if (clr_region) region_err <= 1'b0;
      if (set_wr && !write_enable_bit) wr_no_en <= 1'b1; // RULE7
      else if (clr_noen) wr_no_en <= 1'b0;
    end
  end

  // checks on the link and the shadow state
  hold_on_fourth_a: assert property ((state == ST_HOLD_HI) |->
    (bit_idx == HOLD_BIT) && prog_serial_clock && hold_mode) // RULE2
    else $error("hold phase off the 4th clock");
  hold_length_a: assert property ($rose(state == ST_HOLD_HI) |->
    (timer == HOLD_LD) ##1 prog_serial_clock [*3]) // RULE2
    else $error("hold phase length wrong");
  discharge_low_a: assert property ($fell(state == ST_HOLD_HI) |->
    (state == ST_HOLD_LO) && !prog_serial_clock && (timer == DIS_LD)) // RULE3
    else $error("clock not low for discharge");
  turn_entry_a: assert property ((state == ST_LOW) && tmr_done && turn_here |=>
    (state == ST_TURN) && !prog_serial_clock && !prog_serial_io_oe) // RULE19
    else $error("no turnaround after 8th operand clock");
  read_release_a: assert property (is_read && busy && (bit_idx >= RX_FIRST) |->
    !prog_serial_io_oe) // RULE18
    else $error("data line driven during read byte");
  cmd_lsb_a: assert property ((state == ST_HIGH) && !is_read |->
    prog_serial_io_oe && (prog_serial_io_o == tx[bit_idx])) // RULE18
    else $error("wrong data bit on the line");
  write_enable_bit_guard_a: assert property (set_wr && !write_enable_bit |=> wr_no_en) // RULE7
    else $error("write-start without enable not flagged");
  region_check_a: assert property (region_miss |=> region_err) // RULE4
    else $error("region change not flagged");
  ptr_step_a: assert property (ld_buf |=>
    table_pointer == $past(table_pointer) + PTR_STEP_WR) // RULE11
    else $error("pointer not advanced by two");
  resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");

  read_frame_c: cover property ((state == ST_TURN) ##[1:300] (state == ST_IDLE));
  program_frame_c: cover property ((state == ST_HOLD_HI) ##[1:1000] (state == ST_HOLD_LO));
  region_flag_c: cover property ($rose(region_err));
  noen_flag_c: cover property ($rose(wr_no_en));

endmodule : scm_prog_host

// ===== scm_tb.sv
// self-checking bench of the serial code memory programmer
module tb
  import scm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic flt = 1'b0; // level of the line while nobody drives it
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_last;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic prog_serial_clock, prog_serial_io_o, prog_serial_io_oe, dev_o, dev_oe;
  wire sio;
  logic [65:0] rq[$]; // read notes: resp, mask, data
  logic [1:0] bq[$]; // write response notes
  int n_fail, cmp_count, seed;
  logic [21:0] base;
  logic [15:0] wd [4];
  always #12.5 aclk = ~aclk;
  // undriven line shows a toggling pattern
  always @(posedge aclk) flt <= ~flt;
  assign sio = prog_serial_io_oe ? prog_serial_io_o : (dev_oe ? dev_o : flt);
  scm_prog_host #(.PROG_HOLD_CYCLES(20)) dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .prog_serial_clock, .prog_serial_io_i(sio),
    .prog_serial_io_o, .prog_serial_io_oe);
  scm_dev_model #(.WBUF(8), .HOLD_NS(400)) dev_u (.sclk(prog_serial_clock), .sio(sio),
    .dev_o(dev_o), .dev_oe(dev_oe));
  task automatic chk_r(input logic [65:0] e, input logic [31:0] d, input logic [1:0] r);
    cmp_count++;
    if (r !== e[65:64] || (d & e[63:32]) !== e[31:0]) begin
      n_fail++;
      $display("CHECK FAILED read expected %h/%h seen %h/%h", e[31:0], e[65:64], d & e[63:32], r);
    end
  endtask : chk_r
  task automatic chk_b(input logic [1:0] e, input logic [1:0] r);
    cmp_count++;
    if (r !== e) begin
      n_fail++;
      $display("CHECK FAILED bresp expected %h seen %h", e, r);
    end
  endtask : chk_b
  // monitor: oldest note against each answer
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) chk_r(rq.pop_front(), s_axi_rdata, s_axi_rresp);
    if (s_axi_bvalid && s_axi_bready) chk_b(bq.pop_front(), s_axi_bresp);
  end
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] d,
                        input logic [1:0] r);
    rq.push_back({r, m, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd_last = s_axi_rdata;
  endtask : axi_rd
  task automatic wait_idle();
    int k;
    k = 0;
    do begin
      axi_rd(ADDR_STATUS, 32'h0, 32'h0, RESP_OKAY);
      k++;
    end while (rd_last[0] !== 1'b0 && k < 9000);
    if (rd_last[0] !== 1'b0) begin
      n_fail++; // busy never cleared
      give_verdict();
    end
  endtask : wait_idle
  task automatic frame(input logic [3:0] c, input logic [15:0] p, input logic h);
    axi_wr(ADDR_PAYLOAD, {16'h0, p}, RESP_OKAY);
    axi_wr(ADDR_CTRL, {27'h0, h, c}, RESP_OKAY);
    wait_idle();
  endtask : frame
  task automatic set_ptr(input logic [21:0] a);
    frame(CMD_CORE, {8'h0e, 2'h0, a[21:16]}, 1'b0);
    frame(CMD_CORE, 16'h6ef8, 1'b0);
    frame(CMD_CORE, {8'h0e, a[15:8]}, 1'b0);
    frame(CMD_CORE, 16'h6ef7, 1'b0);
    frame(CMD_CORE, {8'h0e, a[7:0]}, 1'b0);
    frame(CMD_CORE, 16'h6ef6, 1'b0);
    axi_rd(ADDR_PTR, 32'h3fffff, {10'h0, a}, RESP_OKAY);
  endtask : set_ptr
  task automatic rd_byte(input logic [7:0] e);
    frame(CMD_RD_INC, 16'h0, 1'b0);
    axi_rd(ADDR_RDATA, 32'hff, {24'h0, e}, RESP_OKAY);
  endtask : rd_byte
  task automatic give_verdict();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict
  // watchdog against a hang
  initial begin
    repeat (60000) @(posedge aclk);
    n_fail++;
    give_verdict();
  end
  // main sequence
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3f;
    n_fail = 0;
    cmp_count = 0;
    seed = 73;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(ADDR_STATUS, 32'hf, 32'h0, RESP_OKAY);
    axi_rd(8'h20, 32'hffffffff, 32'h0, RESP_SLVERR);
    axi_wr(8'h24, 32'h1, RESP_SLVERR);
    base = 22'($random(seed)) & 22'h00ffc0;
    foreach (wd[i]) wd[i] = 16'($random(seed));
    // start while busy is refused
    axi_wr(ADDR_CTRL, 32'h0, RESP_OKAY);
    axi_wr(ADDR_CTRL, 32'h0, RESP_SLVERR);
    wait_idle();
    // program one write buffer and read it back
    set_ptr(base);
    frame(CMD_CORE, 16'h84a6, 1'b0);
    axi_rd(ADDR_STATUS, 32'h8, 32'h8, RESP_OKAY);
    for (int i = 0; i < 4; i++) frame(i == 3 ? CMD_WR_START : CMD_WR_INC2, wd[i], 1'b0);
    axi_rd(ADDR_PTR, 32'h3fffff, {10'h0, base + 22'h6}, RESP_OKAY);
    axi_rd(ADDR_PAYLOAD, 32'hffff, {16'h0, wd[3]}, RESP_OKAY);
    axi_rd(ADDR_CTRL, 32'h1f, 32'h0f, RESP_OKAY);
    frame(CMD_CORE, 16'h0, 1'b1);
    frame(CMD_CORE, 16'h94a6, 1'b0);
    axi_rd(ADDR_STATUS, 32'hf, 32'h0, RESP_OKAY);
    set_ptr(base);
    for (int i = 0; i < 8; i++) rd_byte(i[0] ? wd[i/2][15:8] : wd[i/2][7:0]);
    axi_rd(ADDR_PTR, 32'h3fffff, {10'h0, base + 22'h8}, RESP_OKAY);
    // erase the block
    set_ptr(base);
    frame(CMD_CORE, 16'h84a6, 1'b0);
    frame(CMD_CORE, 16'h88a6, 1'b0);
    frame(CMD_CORE, 16'h82a6, 1'b0);
    frame(CMD_CORE, 16'h0, 1'b1);
    frame(CMD_CORE, 16'h94a6, 1'b0);
    set_ptr(base);
    rd_byte(8'hff);
    // write-start with write-enable clear
    frame(CMD_CORE, 16'h82a6, 1'b0);
    axi_rd(ADDR_STATUS, 32'h4, 32'h4, RESP_OKAY);
    axi_wr(ADDR_STATUS, 32'h6, RESP_OKAY);
    axi_rd(ADDR_STATUS, 32'h6, 32'h0, RESP_OKAY);
    // pointer leaves the loaded region before programming
    frame(CMD_WR_INC2, wd[0], 1'b0);
    set_ptr(base + 22'h40);
    frame(CMD_WR_START, wd[1], 1'b0);
    axi_rd(ADDR_STATUS, 32'h2, 32'h2, RESP_OKAY);
    give_verdict();
  end
endmodule : tb
